// File: inc/sram_port_pkg.sv
// Shared widths, reset values and enumerations of the burst memory port.
// Assumes nothing of its surroundings; every design file imports it whole.
package sram_port_pkg;

	// ----------------------------------------------------------------
	// Widths and depths
	// ----------------------------------------------------------------
	localparam int ADDR_W    = 19;
	localparam int BURST_W   = 2;
	localparam int DATA_W    = 32;
	localparam int PAR_W     = 4;
	localparam int LANES     = 4;
	localparam int LANE_W    = 8;
	localparam int WORD_W    = DATA_W + PAR_W;
	localparam int MEM_DEPTH = 524288;
	localparam int BUF_W     = ADDR_W + LANES + WORD_W;
	localparam int SYNC_W    = 3;

	// ----------------------------------------------------------------
	// Constants and reset values
	// ----------------------------------------------------------------
	localparam logic [LANES-1:0]   LANES_ALL    = 4'hf;
	localparam logic [LANES-1:0]   LANES_NONE   = 4'h0;
	localparam logic [BURST_W-1:0] BEAT_ZERO    = 2'h0;
	localparam logic [BURST_W-1:0] BEAT_STEP    = 2'h1;
	localparam logic [1:0]         STRAP_SETTLE = 2'h3;
	localparam logic [1:0]         STRAP_RESET  = 2'h0;
	localparam logic [SYNC_W-1:0]  SYNC_RESET   = 3'h5;
	localparam logic [1:0]         COUNT_EMPTY  = 2'h0;
	localparam logic [1:0]         COUNT_ONE    = 2'h1;
	localparam logic [1:0]         COUNT_FULL   = 2'h2;

	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {PORT_DESELECTED, PORT_SELECTED, PORT_SLEEP} portState_type;
	typedef enum logic {ORDER_LINEAR, ORDER_INTERLEAVED} burstOrder_type;

endpackage : sram_port_pkg

// File: logic/burst_counter.sv
// Two-bit wrapping burst counter with linear and interleaved order.
// Assumes load and advance never rise together.
`timescale 1ns/10ps
`default_nettype none
module burst_counter
	import sram_port_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rstn,
	// Control
	input  wire logic                 load,
	input  wire logic                 advance,
	input  wire logic [BURST_W-1:0]   seed,
	input  wire burstOrder_type       order,
	// Address
	output logic      [BURST_W-1:0]   lowBits
);

	logic [BURST_W-1:0] start_reg;
	logic [BURST_W-1:0] start_next;
	logic [BURST_W-1:0] beat_reg;
	logic [BURST_W-1:0] beat_next;

	always_comb begin
		start_next = start_reg;
		beat_next  = beat_reg;
		if (load) begin
			start_next = seed;
			beat_next  = BEAT_ZERO;
		end else if (advance) begin
			beat_next = beat_reg + BEAT_STEP;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			start_reg <= BEAT_ZERO;
			beat_reg  <= BEAT_ZERO;
		end else begin
			start_reg <= start_next;
			beat_reg  <= beat_next;
		end
	end

	// The sum drops its carry on purpose, so the linear order wraps too.
	assign lowBits = (order == ORDER_LINEAR) ? start_reg + beat_reg : start_reg ^ beat_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_burst_seed: assert property (@(posedge clk_sys) disable iff (!rstn)
		load |=> lowBits == $past(seed))
		else $error("burst counter not seeded");
	a_burst_step: assert property (@(posedge clk_sys) disable iff (!rstn)
		advance && !load |=> beat_reg == $past(beat_reg) + BEAT_STEP)
		else $error("burst counter did not step");
	a_burst_wrap: assert property (@(posedge clk_sys) disable iff (!rstn)
		(advance && !load)[*4] |=> lowBits == $past(lowBits, 4))
		else $error("burst did not wrap after four beats");

endmodule : burst_counter
`default_nettype wire

// File: logic/two_entry_buffer.sv
// Two-entry first-in first-out buffer with valid and ready on both sides.
// Assumes both sides run on clk_sys.
`timescale 1ns/10ps
`default_nettype none
module two_entry_buffer
	import sram_port_pkg::*;
#(
	parameter int WIDTH = BUF_W
) (
	// Clock and reset
	input  wire logic               clk_sys,
	input  wire logic               rstn,
	// Fill side
	input  wire logic               inValid,
	output logic                    inReady,
	input  wire logic [WIDTH-1:0]   inData,
	// Drain side
	output logic                    outValid,
	input  wire logic               outReady,
	output logic      [WIDTH-1:0]   outData
);

	logic [WIDTH-1:0] head_reg;
	logic [WIDTH-1:0] head_next;
	logic [WIDTH-1:0] tail_reg;
	logic [WIDTH-1:0] tail_next;
	logic [1:0]       count_reg;
	logic [1:0]       count_next;
	logic             push;
	logic             pop;

	assign inReady  = count_reg != COUNT_FULL;
	assign outValid = count_reg != COUNT_EMPTY;
	assign outData  = head_reg;
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	always_comb begin
		head_next  = head_reg;
		tail_next  = tail_reg;
		count_next = count_reg;
		if (pop) begin
			head_next = (push && count_reg == COUNT_ONE) ? inData : tail_reg;
			if (push) begin
				tail_next = inData;
			end else begin
				count_next = count_reg - COUNT_ONE;
			end
		end else if (push) begin
			if (count_reg == COUNT_EMPTY) begin
				head_next = inData;
			end else begin
				tail_next = inData;
			end
			count_next = count_reg + COUNT_ONE;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			head_reg  <= '0;
			tail_reg  <= '0;
			count_reg <= COUNT_EMPTY;
		end else begin
			head_reg  <= head_next;
			tail_reg  <= tail_next;
			count_reg <= count_next;
		end
	end

endmodule : two_entry_buffer
`default_nettype wire

// File: logic/sram_burst_port.sv
// Memory side of a synchronous pipelined burst static memory port.
// Assumes the controller shares clk_sys; output enable, sleep and strap are asynchronous.
`timescale 1ns/10ps
`default_nettype none
module sram_burst_port
	import sram_port_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rstn,
	// Address and strobes
	input  wire logic [ADDR_W-1:0]    addrIn,
	input  wire logic                 processorAddressStrobeN,
	input  wire logic                 controllerAddressStrobeN,
	input  wire logic                 burstAdvanceN,
	// Chip selects
	input  wire logic                 chipSelectLowAN,
	input  wire logic                 chipSelectHigh,
	input  wire logic                 chipSelectLowBN,
	// Write controls
	input  wire logic                 globalWriteN,
	input  wire logic                 byteWriteEnableN,
	input  wire logic [LANES-1:0]     byteLaneSelectN,
	// Asynchronous controls
	input  wire logic                 outputEnableN,
	input  wire logic                 sleepRequest,
	input  wire logic                 burstOrderStrap,
	// Data lines
	input  wire logic [DATA_W-1:0]    dataIn,
	output logic      [DATA_W-1:0]    dataOut,
	output logic                      dataOe,
	// Parity lines
	input  wire logic [PAR_W-1:0]     parityLinesIn,
	output logic      [PAR_W-1:0]     parityLinesOut,
	output logic                      parityLinesOe
);

	// ----------------------------------------------------------------
	// Lane merge
	// ----------------------------------------------------------------
	function automatic logic [WORD_W-1:0] mergeWord(
		input logic [WORD_W-1:0] oldWord,
		input logic [WORD_W-1:0] newWord,
		input logic [LANES-1:0]  lanes
	);
		logic [WORD_W-1:0] result;
		result = oldWord;
		for (int l = 0; l < LANES; l++) begin
			if (lanes[l]) begin
				result[l*LANE_W +: LANE_W] = newWord[l*LANE_W +: LANE_W];
				result[DATA_W+l]           = newWord[DATA_W+l];
			end
		end
		return result;
	endfunction : mergeWord

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0]         syncFirst_reg, syncSecond_reg;
	logic                      oeActive, sleepNow, strapLevel;
	logic [1:0]                strapWait_reg, strapWait_next;
	burstOrder_type            burstOrder_reg, burstOrder_next;
	portState_type             portState_reg, portState_next;
	logic [ADDR_W-BURST_W-1:0] addrHigh_reg, addrHigh_next;
	logic                      rdPend_reg, rdPend_next, wrPend_reg, wrPend_next;
	logic [LANES-1:0]          wrLanes_reg, wrLanes_next;
	logic [WORD_W-1:0]         wrData_reg, wrData_next, outWord_reg, outWord_next;
	logic                      dqOe_reg, dqOe_next;
	logic                      pStrobe, cStrobe, selNow, accessEn, loadEvent;
	logic                      advance, selectedNext, writeNow, readNow;
	logic [LANES-1:0]          laneMask, headLanes;
	logic [BURST_W-1:0]        burstLowAddressBits, burstBits;
	logic [ADDR_W-1:0]         curAddr, headAddr;
	logic                      bufInReady, bufOutValid, drainReady, headHit;
	logic [BUF_W-1:0]          bufOutData;
	logic [WORD_W-1:0]         headData, memWord, readWord;
	logic [WORD_W-1:0]         mem [MEM_DEPTH];

	// ----------------------------------------------------------------
	// Asynchronous inputs
	// ----------------------------------------------------------------
	// Output enable passes the synchroniser too, so it acts two edges late.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			syncFirst_reg  <= SYNC_RESET;
			syncSecond_reg <= SYNC_RESET;
		end else begin
			syncFirst_reg  <= {burstOrderStrap, sleepRequest, outputEnableN};
			syncSecond_reg <= syncFirst_reg;
		end
	end

	assign oeActive   = !syncSecond_reg[0];
	assign sleepNow   = syncSecond_reg[1];
	assign strapLevel = syncSecond_reg[2];

	// The strap is followed until the synchroniser has settled, then frozen.
	always_comb begin
		strapWait_next  = strapWait_reg;
		burstOrder_next = burstOrder_reg;
		if (strapWait_reg != STRAP_SETTLE) begin
			strapWait_next  = strapWait_reg + COUNT_ONE;
			burstOrder_next = strapLevel ? ORDER_INTERLEAVED : ORDER_LINEAR;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			strapWait_reg  <= STRAP_RESET;
			burstOrder_reg <= ORDER_INTERLEAVED;
		end else begin
			strapWait_reg  <= strapWait_next;
			burstOrder_reg <= burstOrder_next;
		end
	end

	// ----------------------------------------------------------------
	// Strobe and select decode
	// ----------------------------------------------------------------
	assign pStrobe      = !processorAddressStrobeN && !chipSelectLowAN;
	assign cStrobe      = !controllerAddressStrobeN && !pStrobe;
	assign selNow       = !chipSelectLowAN && chipSelectHigh && !chipSelectLowBN;
	assign accessEn     = !sleepNow && portState_reg != PORT_SLEEP && bufInReady;
	assign loadEvent    = accessEn && (pStrobe || cStrobe);
	assign advance      = accessEn && !loadEvent && !burstAdvanceN
		&& portState_reg == PORT_SELECTED;
	assign selectedNext = loadEvent ? selNow : (portState_reg == PORT_SELECTED);
	// Partial writes rely on the controller pairing enable and lane selects.
	assign laneMask     = !globalWriteN ? LANES_ALL
		: (!byteWriteEnableN ? ~byteLaneSelectN : LANES_NONE);
	assign writeNow     = selectedNext && laneMask != LANES_NONE;
	assign readNow      = selectedNext && laneMask == LANES_NONE;

	assign burstLowAddressBits = addrIn[BURST_W-1:0];
	assign curAddr             = {addrHigh_reg, burstBits};

	burst_counter u_counter (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.load    (loadEvent && selNow),
		.advance (advance),
		.seed    (burstLowAddressBits),
		.order   (burstOrder_reg),
		.lowBits (burstBits)
	);

	// ----------------------------------------------------------------
	// Port state and input registers
	// ----------------------------------------------------------------
	always_comb begin
		portState_next = portState_reg;
		addrHigh_next  = addrHigh_reg;
		rdPend_next    = 1'h0;
		wrPend_next    = wrPend_reg;
		wrLanes_next   = wrLanes_reg;
		wrData_next    = wrData_reg;
		if (accessEn) begin
			wrPend_next  = writeNow;
			wrLanes_next = laneMask;
			wrData_next  = {parityLinesIn, dataIn};
			rdPend_next  = readNow;
		end else if (bufInReady) begin
			wrPend_next = 1'h0;
		end
		if (loadEvent && selNow) begin
			addrHigh_next = addrIn[ADDR_W-1:BURST_W];
		end
		case (portState_reg)
			PORT_SLEEP: begin
				if (!sleepNow) begin
					portState_next = PORT_DESELECTED;
				end
			end
			PORT_DESELECTED, PORT_SELECTED: begin
				if (sleepNow) begin
					portState_next = PORT_SLEEP;
				end else if (loadEvent) begin
					portState_next = selNow ? PORT_SELECTED : PORT_DESELECTED;
				end
			end
			default: begin
				portState_next = PORT_DESELECTED;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			portState_reg <= PORT_DESELECTED;
			addrHigh_reg  <= '0;
			rdPend_reg    <= 1'h0;
			wrPend_reg    <= 1'h0;
			wrLanes_reg   <= LANES_NONE;
			wrData_reg    <= '0;
		end else begin
			portState_reg <= portState_next;
			addrHigh_reg  <= addrHigh_next;
			rdPend_reg    <= rdPend_next;
			wrPend_reg    <= wrPend_next;
			wrLanes_reg   <= wrLanes_next;
			wrData_reg    <= wrData_next;
		end
	end

	// ----------------------------------------------------------------
	// Write buffer and array
	// ----------------------------------------------------------------
	// Draining stops in sleep; a full buffer then stalls the port, losing no write.
	assign drainReady = !sleepNow;

	two_entry_buffer #(
		.WIDTH (BUF_W)
	) u_wrbuf (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.inValid  (wrPend_reg),
		.inReady  (bufInReady),
		.inData   ({curAddr, wrLanes_reg, wrData_reg}),
		.outValid (bufOutValid),
		.outReady (drainReady),
		.outData  (bufOutData)
	);

	assign headAddr  = bufOutData[BUF_W-1 -: ADDR_W];
	assign headLanes = bufOutData[WORD_W +: LANES];
	assign headData  = bufOutData[WORD_W-1:0];

	always_ff @(posedge clk_sys) begin
		if (bufOutValid && drainReady) begin
			mem[headAddr] <= mergeWord(mem[headAddr], headData, headLanes);
		end
	end

	// The write at the head of the buffer is forwarded, so a read right behind it sees it.
	assign memWord  = mem[curAddr];
	assign headHit  = bufOutValid && headAddr == curAddr;
	assign readWord = headHit ? mergeWord(memWord, headData, headLanes) : memWord;

	// ----------------------------------------------------------------
	// Output stage
	// ----------------------------------------------------------------
	always_comb begin
		outWord_next = rdPend_reg ? readWord : outWord_reg;
		dqOe_next    = oeActive && rdPend_reg && !sleepNow;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			outWord_reg <= '0;
			dqOe_reg    <= 1'h0;
		end else begin
			outWord_reg <= outWord_next;
			dqOe_reg    <= dqOe_next;
		end
	end

	assign dataOut        = outWord_reg[DATA_W-1:0];
	assign parityLinesOut = outWord_reg[WORD_W-1:DATA_W];
	assign dataOe         = dqOe_reg;
	assign parityLinesOe  = dqOe_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_load_select: assert property (@(posedge clk_sys) disable iff (!rstn)
		loadEvent && selNow |=> portState_reg == PORT_SELECTED
			&& addrHigh_reg == $past(addrIn[ADDR_W-1:BURST_W]))
		else $error("selected address not captured");
	a_load_seed: assert property (@(posedge clk_sys) disable iff (!rstn)
		loadEvent && selNow |=> burstBits == $past(addrIn[BURST_W-1:0]))
		else $error("low address bits not loaded");
	a_chip_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
		!loadEvent && !sleepNow && portState_reg != PORT_SLEEP
			|=> portState_reg == $past(portState_reg))
		else $error("selection changed without an address");
	a_strobe_ignored: assert property (@(posedge clk_sys) disable iff (!rstn)
		!processorAddressStrobeN && chipSelectLowAN && controllerAddressStrobeN
			&& accessEn
			|=> $stable(addrHigh_reg) && portState_reg == $past(portState_reg))
		else $error("processor strobe taken with first select high");
	a_strobe_priority: assert property (@(posedge clk_sys) disable iff (!rstn)
		!processorAddressStrobeN && !controllerAddressStrobeN && !chipSelectLowAN
			|-> pStrobe && !cStrobe)
		else $error("controller strobe acted beside processor strobe");
	a_global_write: assert property (@(posedge clk_sys) disable iff (!rstn)
		accessEn && selectedNext && !globalWriteN |=> wrPend_reg && wrLanes_reg == LANES_ALL)
		else $error("global write missed a lane");
	a_lane_write: assert property (@(posedge clk_sys) disable iff (!rstn)
		accessEn && selectedNext && globalWriteN && !byteWriteEnableN
			|=> wrLanes_reg == ~$past(byteLaneSelectN))
		else $error("byte lanes written wrongly");
	a_lane_blocked: assert property (@(posedge clk_sys) disable iff (!rstn)
		accessEn && globalWriteN && byteWriteEnableN |=> !wrPend_reg)
		else $error("write without byte write enable");
	a_output_float: assert property (@(posedge clk_sys) disable iff (!rstn)
		!oeActive |=> !dataOe && !parityLinesOe)
		else $error("lines driven with output enable high");
	a_first_read: assert property (@(posedge clk_sys) disable iff (!rstn)
		portState_reg == PORT_DESELECTED && loadEvent && selNow |=> !dataOe)
		else $error("outputs enabled on first read clock");
	a_read_latency: assert property (@(posedge clk_sys) disable iff (!rstn)
		rdPend_reg && !headHit |=> {parityLinesOut, dataOut} == $past(memWord))
		else $error("read data not from previous address");
	a_sleep_quiet: assert property (@(posedge clk_sys) disable iff (!rstn)
		sleepNow |=> !dataOe && portState_reg == PORT_SLEEP)
		else $error("activity during sleep");
	a_write_capture: assert property (@(posedge clk_sys) disable iff (!rstn)
		accessEn |=> wrData_reg == $past({parityLinesIn, dataIn}))
		else $error("write data not captured");

endmodule : sram_burst_port
`default_nettype wire

// File: dv/ctrl_bus_model.sv
// Controller-side model of the shared data and parity lines.
// Assumes the bench raises ctrlOe only on cycles with global or byte write enable low, selected or not.
`timescale 1ns/10ps
`default_nettype none
module ctrl_bus_model
	import sram_port_pkg::*;
(
	// Device side
	input  wire logic [WORD_W-1:0] devWord,
	input  wire logic              devOe,
	// Controller side
	input  wire logic [WORD_W-1:0] ctrlWord,
	input  wire logic              ctrlOe,
	output logic      [WORD_W-1:0] busWord
);
	logic [WORD_W-1:0] lastWord = '0;
	// A released line shows the inverse of its last level so stale data never looks valid.
	always_comb begin
		if (ctrlOe) busWord = ctrlWord;
		else if (devOe) busWord = devWord;
		else busWord = ~lastWord;
	end
	always @(busWord) if (ctrlOe || devOe) lastWord = busWord;
endmodule : ctrl_bus_model
`default_nettype wire

// File: dv/tb_pipelined_burst_sram_port.sv
// Self-checking bench of the burst memory port against a queue-free word model.
// Assumes the port runs on clk_sys and the line model is combinational; the memory array is not reset.
`timescale 1ns/10ps
`default_nettype none
module tb_pipelined_burst_sram_port;
	import sram_port_pkg::*;
	logic              clk_sys = 0, rstn = 0, pS = 1, cS = 1, advN = 1;
	logic              ce1N = 1, ce2 = 0, ce3N = 1, gwN = 1, bweN = 1;
	logic              oeN = 1, sleep = 0, strap = 0, ctrlOe = 0, dataOe, parityLinesOe;
	logic [LANES-1:0]  blsN = 4'hf;
	logic [ADDR_W-1:0] addrIn = '0, base;
	logic [WORD_W-1:0] ctrlWord = '0, busWord, expW;
	logic [DATA_W-1:0] dataOut;
	logic [PAR_W-1:0]  parityLinesOut;
	logic [1:0]        beat;
	logic [WORD_W-1:0] mem [int];
	bit                sel, rd, chk, o1, o2, ord, ign;
	int                error_cnt = 0, comparisons = 0, cycles = 0;

	sram_burst_port dut_u (.clk_sys(clk_sys), .rstn(rstn), .addrIn(addrIn),
		.processorAddressStrobeN(pS), .controllerAddressStrobeN(cS),
		.burstAdvanceN(advN), .chipSelectLowAN(ce1N), .chipSelectHigh(ce2),
		.chipSelectLowBN(ce3N), .globalWriteN(gwN), .byteWriteEnableN(bweN),
		.byteLaneSelectN(blsN), .outputEnableN(oeN), .sleepRequest(sleep),
		.burstOrderStrap(strap), .dataIn(busWord[DATA_W-1:0]), .dataOut(dataOut),
		.dataOe(dataOe), .parityLinesIn(busWord[WORD_W-1:DATA_W]),
		.parityLinesOut(parityLinesOut), .parityLinesOe(parityLinesOe));
	ctrl_bus_model ctrl_u (.devWord({parityLinesOut, dataOut}), .devOe(dataOe),
		.ctrlWord(ctrlWord), .ctrlOe(ctrlOe), .busWord(busWord));

	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles > 20000) begin
			error_cnt++;
			final_report();
		end
	end

	task check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : check

	task final_report;
		if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : final_report

	// ----------------------------------------------------------------
	// One clock: check last edge's answer, then model this edge
	// ----------------------------------------------------------------
	task step;
		logic             p, c;
		logic [1:0]       lo;
		logic [LANES-1:0] ln;
		int               a;
		@(posedge clk_sys);
		#1;
		check(WORD_W'({dataOe, parityLinesOe}), WORD_W'({2{rd && o2}}));
		if (chk) check({parityLinesOut, dataOut}, expW);
		o2 = o1;
		o1 = !oeN;
		if (ign) return;
		p = !pS && !ce1N;
		c = !cS && !p;
		if (p || c) begin
			sel = !ce1N && ce2 && !ce3N;
			if (sel) base = addrIn;
			if (sel) beat = 2'h0;
		end else if (sel && !advN) beat++;
		lo = ord ? base[1:0] ^ beat : base[1:0] + beat;
		a = int'({base[ADDR_W-1:2], lo});
		ln = !gwN ? LANES_ALL : (!bweN ? ~blsN : LANES_NONE);
		rd = sel && ln == LANES_NONE;
		if (sel && !mem.exists(a) && ln != LANES_NONE) mem[a] = 'x;
		for (int k = 0; k < LANES; k++) if (sel && ln[k]) begin
			mem[a][8*k +: 8] = busWord[8*k +: 8];
			mem[a][DATA_W+k] = busWord[DATA_W+k];
		end
		chk = rd && mem.exists(a);
		if (chk) chk = !$isunknown(mem[a]);
		if (chk) expW = mem[a];
	endtask : step

	task rnd;
		{pS, cS, bweN} = 3'($urandom);
		advN = ($urandom % 3) == 0;
		ce1N = ($urandom % 6) == 0;
		ce2 = ($urandom % 6) != 0;
		ce3N = ($urandom % 6) == 0;
		gwN = ($urandom % 4) != 0;
		blsN = 4'($urandom);
		oeN = ($urandom % 10) == 0;
		addrIn = ADDR_W'($urandom % 16);
		ctrlWord = WORD_W'({$urandom, $urandom});
		ctrlOe = !gwN || !bweN;
	endtask : rnd

	initial begin
		void'($urandom(90));
		for (int s = 0; s < 2; s++) begin
			rstn = 0;
			strap = s[0];
			ord = s[0];
			{sel, rd, chk, o1, o2} = 5'h0;
			{pS, cS, ctrlOe} = 3'h6;
			repeat (16) @(posedge clk_sys);
			#1 rstn = 1;
			// The burst order is only known once the strap has passed its synchroniser.
			repeat (3) step();
			// Every location the random phase can reach is filled, so no read sees unknowns.
			for (int i = 0; i < 16; i++) begin
				{pS, cS, advN, ce1N, ce2, ce3N, gwN, bweN, ctrlOe} = 9'h0d3;
				addrIn = ADDR_W'(i);
				ctrlWord = WORD_W'({$urandom, $urandom});
				step();
			end
			repeat (400) begin
				rnd();
				step();
			end
			// Sleep is entered from a deselected state, so no read is in flight.
			{ce1N, cS, pS, gwN, bweN, ctrlOe} = 6'h3e;
			cS = 0;
			step();
			cS = 1;
			sleep = 1;
			repeat (2) step();
			// A global write offered while asleep must leave the array untouched.
			{pS, ce1N, ce2, ce3N, gwN, ctrlOe} = 6'h09;
			addrIn = '0;
			ctrlWord = ~mem[0];
			ign = 1;
			repeat (6) step();
			{pS, ce1N, gwN, ctrlOe} = 4'ha;
			sleep = 0;
			repeat (4) step();
			ign = 0;
			{pS, ce1N, ce2, ce3N, advN} = 5'h05;
			step();
			repeat (400) begin
				rnd();
				step();
			end
			// Idle edges let the write buffer drain before the next reset.
			{pS, cS, gwN, bweN, ctrlOe} = 5'h1e;
			repeat (3) step();
		end
		final_report();
	end
endmodule : tb_pipelined_burst_sram_port
`default_nettype wire
